// File: sps_sequencer.sv
// Self-programming flash sequencer: timed commands, page buffer, lock bits
`timescale 1ns/10ps
module sps_sequencer #(
    parameter int         PROG_CYCLES = sps_pkg::PROG_MIN_CYC,
    parameter logic [7:0] SIG_BYTE0   = 8'h5A, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE1   = 8'h3C, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE2   = 8'hA5  // Arbitrary identity value
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 sys_reset_in,
    input  wire logic                 ctrl_wr_in,
    input  wire logic [7:0]           ctrl_wdata_in,
    output logic      [7:0]           ctrl_rdata_out,
    input  wire sps_pkg::sps_cpu_req_t cpu_req_in,
    output logic                      load_valid_out,
    output logic      [7:0]           load_data_out,
    input  wire logic                 eeprom_write_active_in,
    input  wire logic [7:0]           fuse_low_byte_in,
    input  wire logic [7:0]           fuse_high_byte_in,
    input  wire logic [7:0]           fuse_extended_byte_in,
    input  wire logic [7:0]           calib_byte_in,
    output sps_pkg::sps_flash_t       flash_cmd_out,
    input  wire logic [5:0]           buf_rd_idx_in,
    output logic      [15:0]          buf_rd_data_out,
    output logic      [7:0]           lock_bits_out,
    output logic                      halt_cpu_out,
    output logic                      rww_read_block_out,
    output logic                      spm_irq_out
);

    typedef struct packed {
        sps_pkg::sps_state_t     state;
        logic [5:0]              ctl;       // Command bits of control reg
        logic                    int_en;
        logic                    area_busy;
        logic [2:0]              win;
        logic [7:0]              lock_data;
        logic [7:0]              locks;
        logic                    ld_valid;
        logic [7:0]              ld_data;
        sps_pkg::sps_flash_t     flash;
        logic [15:0]             rd_data;
        logic [sps_pkg::BUF_WORDS-1:0][15:0] pbuf;
    } sps_seq_state_t;

    sps_seq_state_t   st_reg;
    sps_seq_state_t   st_next;
    sps_pkg::sps_cmd_t cmd_kind;
    logic             tmr_start;
    logic             tmr_done;
    logic             eep_idle;
    logic             store_ok;
    logic             load_ok;
    logic             win_end;
    logic [5:0]       word_idx;

    // Command decode from control bits 5..0
    function automatic sps_pkg::sps_cmd_t sps_decode(input logic [5:0] c);
        sps_pkg::sps_cmd_t k;
        unique case (c)
            sps_pkg::PAT_FILL:  k = sps_pkg::SPS_CMD_FILL;
            sps_pkg::PAT_ERASE: k = sps_pkg::SPS_CMD_ERASE;
            sps_pkg::PAT_WRITE: k = sps_pkg::SPS_CMD_WRITE;
            sps_pkg::PAT_LOCK:  k = sps_pkg::SPS_CMD_LOCK;
            sps_pkg::PAT_REEN:  k = sps_pkg::SPS_CMD_REEN;
            sps_pkg::PAT_SIG:   k = sps_pkg::SPS_CMD_SIG;
            default:            k = sps_pkg::SPS_CMD_NONE;
        endcase
        return k;
    endfunction : sps_decode

    // Page lies in the area that cannot be read while written
    function automatic logic sps_is_no_read_while_write_area(input logic [6:0] page);
        return page >= sps_pkg::NO_READ_WHILE_WRITE_AREA_FIRST_PAGE;
    endfunction : sps_is_no_read_while_write_area

    // Value returned by a special program-load
    function automatic logic [7:0] sps_read_value(
        input sps_pkg::sps_cmd_t k,
        input logic [15:0]       a,
        input logic [7:0]        locks
    );
        logic [7:0] v;
        v = sps_pkg::RESERVED_RD;
        if (k == sps_pkg::SPS_CMD_LOCK) begin
            // R16 fuse byte select
            unique case (a)
                sps_pkg::ADDR_FUSE_LO:  v = fuse_low_byte_in;
                // R15 lock bit layout
                sps_pkg::ADDR_LOCK:     v = locks;
                sps_pkg::ADDR_FUSE_EXT: v = fuse_extended_byte_in;
                sps_pkg::ADDR_FUSE_HI:  v = fuse_high_byte_in;
                default:                v = sps_pkg::RESERVED_RD;
            endcase
        end else begin
            // R19 signature row select
            unique case (a)
                sps_pkg::ADDR_SIG0:  v = SIG_BYTE0;
                sps_pkg::ADDR_CALIB: v = calib_byte_in;
                sps_pkg::ADDR_SIG1:  v = SIG_BYTE1;
                sps_pkg::ADDR_SIG2:  v = SIG_BYTE2;
                default:             v = sps_pkg::RESERVED_RD;
            endcase
        end
        return v;
    endfunction : sps_read_value

    // R21 operation timing
    sps_prog_timer #(
        .CYCLES      (PROG_CYCLES)
    ) u_prog_timer (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .start_in    (tmr_start),
        .done_out    (tmr_done)
    );

    // Window checks for the armed command
    assign cmd_kind = sps_decode(st_reg.ctl);
    assign word_idx = cpu_req_in.addr[sps_pkg::WORD_LSB +: sps_pkg::WORD_W];
    // R11 EEPROM write refusal
    assign eep_idle = !eeprom_write_active_in;
    // R1 store window
    assign store_ok = (st_reg.state == sps_pkg::SPS_ARMED) &&
                      cpu_req_in.store && eep_idle &&
                      (st_reg.win < sps_pkg::STORE_WIN) &&
                      (cmd_kind != sps_pkg::SPS_CMD_SIG);
    // R13 load window
    assign load_ok  = (st_reg.state == sps_pkg::SPS_ARMED) &&
                      cpu_req_in.load && eep_idle &&
                      (st_reg.win < sps_pkg::LOAD_WIN) &&
                      ((cmd_kind == sps_pkg::SPS_CMD_LOCK) ||
                       (cmd_kind == sps_pkg::SPS_CMD_SIG));
    // R14 window expiry
    // R18 shorter signature window
    assign win_end  = (cmd_kind == sps_pkg::SPS_CMD_SIG) ?
                      (st_reg.win == sps_pkg::LOAD_WIN - 3'h1) :
                      (st_reg.win == sps_pkg::STORE_WIN - 3'h1);

    // Next-state logic of the sequencer
    always_comb begin
        st_next          = st_reg;
        st_next.ld_valid = 1'b0;
        st_next.rd_data  = st_reg.pbuf[buf_rd_idx_in];
        tmr_start        = 1'b0;
        if (ctrl_wr_in) begin
            st_next.int_en = ctrl_wdata_in[sps_pkg::CTL_IE];
        end
        unique case (st_reg.state)
            sps_pkg::SPS_IDLE: begin
                // R11 refused while EEPROM busy
                if (ctrl_wr_in && eep_idle &&
                    ctrl_wdata_in[sps_pkg::CTL_EN] &&
                    sps_decode(ctrl_wdata_in[5:0]) !=
                    sps_pkg::SPS_CMD_NONE) begin
                    st_next.ctl   = ctrl_wdata_in[5:0];
                    st_next.state = sps_pkg::SPS_ARMED;
                    st_next.win   = '0;
                end
            end
            sps_pkg::SPS_ARMED: begin
                st_next.win = st_reg.win + 3'h1;
                if (load_ok) begin
                    // R17 raw programmed-zero values
                    st_next.ld_data  = sps_read_value(cmd_kind,
                        cpu_req_in.addr, st_reg.locks);
                    st_next.ld_valid = 1'b1;
                    // R14 clear on read
                    st_next.ctl      = '0;
                    st_next.state    = sps_pkg::SPS_IDLE;
                end else if (store_ok) begin
                    st_next.ctl   = '0;
                    st_next.state = sps_pkg::SPS_IDLE;
                    unique case (cmd_kind)
                        sps_pkg::SPS_CMD_FILL: begin
                            // R23 buffer word load
                            st_next.pbuf[word_idx] = cpu_req_in.data;
                        end
                        sps_pkg::SPS_CMD_ERASE,
                        sps_pkg::SPS_CMD_WRITE: begin
                            // R2 page index only
                            st_next.flash.page = cpu_req_in.addr[
                                sps_pkg::PAGE_LSB +: sps_pkg::PAGE_W];
                            // R22 page erase start
                            st_next.flash.erase =
                                (cmd_kind == sps_pkg::SPS_CMD_ERASE);
                            st_next.flash.write =
                                (cmd_kind == sps_pkg::SPS_CMD_WRITE);
                            // R5 area busy set
                            st_next.area_busy = 1'b1;
                            // R25 enable held until done
                            st_next.ctl   = st_reg.ctl;
                            st_next.state = sps_pkg::SPS_BUSY;
                            tmr_start     = 1'b1;
                        end
                        sps_pkg::SPS_CMD_LOCK: begin
                            // R7 lock data capture
                            st_next.lock_data = cpu_req_in.data[7:0];
                            st_next.ctl   = st_reg.ctl;
                            st_next.state = sps_pkg::SPS_BUSY;
                            tmr_start     = 1'b1;
                        end
                        sps_pkg::SPS_CMD_REEN: begin
                            // R24 buffer erase on re-enable
                            st_next.area_busy = 1'b0;
                            st_next.pbuf = {sps_pkg::BUF_WORDS{
                                sps_pkg::BUF_ERASED}};
                        end
                        default: begin
                            st_next.ctl = '0;
                        end
                    endcase
                end else if (win_end) begin
                    // R14 missed window clear
                    st_next.ctl   = '0;
                    st_next.state = sps_pkg::SPS_IDLE;
                end
            end
            sps_pkg::SPS_BUSY: begin
                if (tmr_done) begin
                    if (st_reg.flash.write) begin
                        // R24 buffer erase after write
                        st_next.pbuf = {sps_pkg::BUF_WORDS{
                            sps_pkg::BUF_ERASED}};
                    end
                    if (cmd_kind == sps_pkg::SPS_CMD_LOCK) begin
                        // R8 zero bits program locks
                        st_next.locks = st_reg.locks &
                            (st_reg.lock_data | ~sps_pkg::LOCK_MASK);
                    end
                    st_next.flash.erase = 1'b0;
                    st_next.flash.write = 1'b0;
                    // R25 enable clear marks done
                    st_next.ctl   = '0;
                    st_next.state = sps_pkg::SPS_IDLE;
                end
            end
            default: begin
                st_next.state = sps_pkg::SPS_IDLE;
            end
        endcase
        // R20 system reset spares a running write
        if (sys_reset_in && st_next.state != sps_pkg::SPS_BUSY) begin
            st_next.ctl   = '0;
            st_next.state = sps_pkg::SPS_IDLE;
            st_next.int_en = 1'b0;
            // R24 buffer erase on system reset
            st_next.pbuf  = {sps_pkg::BUF_WORDS{sps_pkg::BUF_ERASED}};
        end
    end

    // State register; locks and buffer power up unprogrammed
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg       <= '0;
            st_reg.locks <= sps_pkg::LOCK_RESET;
            st_reg.pbuf  <= {sps_pkg::BUF_WORDS{sps_pkg::BUF_ERASED}};
        end else begin
            st_reg <= st_next;
        end
    end

    // Control register readback
    assign ctrl_rdata_out  = {st_reg.int_en, st_reg.area_busy, st_reg.ctl};
    assign load_valid_out  = st_reg.ld_valid;
    assign load_data_out   = st_reg.ld_data;
    assign flash_cmd_out   = st_reg.flash;
    assign buf_rd_data_out = st_reg.rd_data;
    assign lock_bits_out   = st_reg.locks;

    // R3 halt for no-read-while-write target
    assign halt_cpu_out = (st_reg.state == sps_pkg::SPS_BUSY) &&
                          (st_reg.flash.erase || st_reg.flash.write) &&
                          sps_is_no_read_while_write_area(st_reg.flash.page);

    // R5 read block, lock writes excluded
    // R10 lock programming keeps reads
    assign rww_read_block_out = st_reg.area_busy;

    // R4 level interrupt while enable clear
    assign spm_irq_out = st_reg.int_en && !st_reg.ctl[sps_pkg::CTL_EN];

endmodule : sps_sequencer

// File: sps_pkg.sv
// Constants and types shared by the self-programming flash sequencer
//
// Overview of operation
// R1 - Page write starts on pattern X0000101 then program-store within four cycles.
// R2 - Page write ignores the data pair and uses only the page index field.
// R3 - Writing a no-read-while-write page halts the CPU until it finishes.
// R4 - Interrupt is asserted as a level while enabled and the enable bit clear.
// R5 - Erase or write blocks area reads; area busy flag stays set meanwhile.
// R6 - Software clears the busy flag via re-enable before using the area.
// R7 - Lock programming: data low byte, pattern X0001001, store within four cycles.
// R8 - Each zero among data bits 5..0 programs its lock bit; pointer ignored.
// R9 - Software should use pointer 0x0001 and data bits 7 and 6 set.
// R10 - Lock programming never blocks flash reads.
// R11 - EEPROM write in progress refuses programming and fuse or lock reads.
// R12 - Software should check the EEPROM write bit before writing control.
// R13 - Lock read: pointer 0x0001, lock access and enable, load within three.
// R14 - Lock access and enable clear on read, or missed load or store window.
// R15 - Lock read returns the six lock bits in bits 5..0, top two unused.
// R16 - Fuse read: pointer 0x0000 low, 0x0003 high, 0x0002 extended byte.
// R17 - Programmed fuse or lock bits read zero, unprogrammed ones read one.
// R18 - Signature read: signature and enable bits, load within three cycles.
// R19 - Signature addresses 0, 2, 4 give identity bytes, 1 gives calibration.
// R20 - A reset during a flash write lets the write complete.
// R21 - Erase, write and lock programming each last 3.7 ms to 4.5 ms.
// R22 - Page erase: pattern X0000011, store within four cycles, data ignored.
// R23 - Buffer load: pattern 00000001, word index and data, store within four.
// R24 - Page buffer is erased after page write, re-enable, or system reset; a system reset during erase or lock programming leaves it as is.
// R25 - Enable bit stays set until the operation ends; clearing means completion.
package sps_pkg;

    // Control register bit positions
    localparam int CTL_EN    = 0;
    localparam int CTL_ERASE = 1;
    localparam int CTL_WRITE = 2;
    localparam int CTL_LOCK  = 3;
    localparam int CTL_REEN  = 4;
    localparam int CTL_SIG   = 5;
    localparam int CTL_BUSY  = 6;
    localparam int CTL_IE    = 7;

    // Command patterns on control bits 5..0
    localparam logic [5:0] PAT_FILL  = 6'h01;
    localparam logic [5:0] PAT_ERASE = 6'h03;
    localparam logic [5:0] PAT_WRITE = 6'h05;
    localparam logic [5:0] PAT_LOCK  = 6'h09;
    localparam logic [5:0] PAT_REEN  = 6'h11;
    localparam logic [5:0] PAT_SIG   = 6'h21;

    // Instruction windows, counted from the cycle after the control write
    localparam logic [2:0] STORE_WIN = 3'h4;
    localparam logic [2:0] LOAD_WIN  = 3'h3;

    // Pointer fields
    localparam int PAGE_LSB = 7;
    localparam int PAGE_W   = 7;
    localparam int WORD_LSB = 1;
    localparam int WORD_W   = 6;
    localparam int BUF_WORDS = 64;
    localparam logic [6:0] NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 7'h70;

    // Fuse, lock and signature pointer values
    localparam logic [15:0] ADDR_FUSE_LO  = 16'h0000;
    localparam logic [15:0] ADDR_LOCK     = 16'h0001;
    localparam logic [15:0] ADDR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] ADDR_FUSE_HI  = 16'h0003;
    localparam logic [15:0] ADDR_SIG0     = 16'h0000;
    localparam logic [15:0] ADDR_CALIB    = 16'h0001;
    localparam logic [15:0] ADDR_SIG1     = 16'h0002;
    localparam logic [15:0] ADDR_SIG2     = 16'h0004;
    localparam logic [7:0]  RESERVED_RD   = 8'hFF;

    // Reset and erased values
    localparam logic [7:0]  LOCK_RESET = 8'hFF;
    localparam logic [7:0]  LOCK_MASK  = 8'h3F;
    localparam logic [15:0] BUF_ERASED = 16'hFFFF;

    // Programming time from the 20 MHz core clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_MIN_NS   = 3700000;
    localparam int PROG_MAX_NS   = 4500000;
    localparam int PROG_MIN_CYC  =
        (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYC  = PROG_MAX_NS / CLK_PERIOD_NS;
    localparam int TMR_W         = 17;

    typedef enum logic [1:0] {
        SPS_IDLE,
        SPS_ARMED,
        SPS_BUSY
    } sps_state_t;

    typedef enum logic [2:0] {
        SPS_CMD_NONE,
        SPS_CMD_FILL,
        SPS_CMD_ERASE,
        SPS_CMD_WRITE,
        SPS_CMD_LOCK,
        SPS_CMD_REEN,
        SPS_CMD_SIG
    } sps_cmd_t;

    // Instruction request from the core
    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] addr;
        logic [15:0] data;
    } sps_cpu_req_t;

    // Command to the flash array
    typedef struct packed {
        logic        erase;
        logic        write;
        logic [6:0]  page;
    } sps_flash_t;

endpackage : sps_pkg

// File: sps_prog_timer.sv
// Programming duration timer for flash write operations
`timescale 1ns/10ps
module sps_prog_timer #(
    parameter int CYCLES = sps_pkg::PROG_MIN_CYC
) (
    input  wire logic core_clk_in,
    input  wire logic reset_n_in,
    input  wire logic start_in,
    output logic      done_out
);

    typedef struct packed {
        logic [sps_pkg::TMR_W-1:0] cnt;
        logic                      run;
        logic                      done;
    } sps_tmr_state_t;

    localparam logic [sps_pkg::TMR_W-1:0] LAST =
        sps_pkg::TMR_W'(CYCLES - 1);

    sps_tmr_state_t tmr_reg;
    sps_tmr_state_t tmr_next;

    // Count down one operation, pulse at its end
    always_comb begin
        tmr_next      = tmr_reg;
        tmr_next.done = 1'b0;
        if (start_in) begin
            tmr_next.cnt = LAST;
            tmr_next.run = 1'b1;
        end else if (tmr_reg.run) begin
            if (tmr_reg.cnt == '0) begin
                tmr_next.run  = 1'b0;
                tmr_next.done = 1'b1;
            end else begin
                tmr_next.cnt = tmr_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign done_out = tmr_reg.done;

endmodule : sps_prog_timer

// File: sps_seq_monitor.sv
// Port assertions for the flash sequencer
`timescale 1ns/10ps
module sps_seq_monitor #(
    parameter int PROG_CYCLES = 8
) (
    input wire logic                  core_clk_in,
    input wire logic                  reset_n_in,
    input wire logic [7:0]            ctrl_rdata_out,
    input wire sps_pkg::sps_cpu_req_t cpu_req_in,
    input wire logic                  load_valid_out,
    input wire logic                  eeprom_write_active_in,
    input wire sps_pkg::sps_flash_t   flash_cmd_out,
    input wire logic [7:0]            lock_bits_out,
    input wire logic                  halt_cpu_out,
    input wire logic                  rww_read_block_out,
    input wire logic                  spm_irq_out
);
    localparam int DONE_MAX = PROG_CYCLES + 2;
    logic prog;

    // Flash array busy with erase or write
    assign prog = flash_cmd_out.erase | flash_cmd_out.write;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    // Output relations
    irq_level_a: assert property (
        spm_irq_out == (ctrl_rdata_out[7] & ~ctrl_rdata_out[0]))
        else $error("irq level wrong");
    busy_flag_a: assert property (
        prog |-> rww_read_block_out && ctrl_rdata_out[6])
        else $error("busy flag low during program");
    halt_page_a: assert property (
        halt_cpu_out == (prog && flash_cmd_out.page >= 7'h70))
        else $error("halt does not match page");
    lock_top_a: assert property (
        lock_bits_out[7:6] == 2'b11)
        else $error("lock top bits not one");
    enable_held_a: assert property (
        prog |-> ctrl_rdata_out[0])
        else $error("enable clear while busy");
    lock_noblock_a: assert property (
        ctrl_rdata_out[5:0] == 6'h09 |-> !prog)
        else $error("lock command blocks flash");
    load_answer_a: assert property (
        load_valid_out |-> $past(cpu_req_in.load) && !ctrl_rdata_out[0])
        else $error("load answer without load");
    ee_refuse_a: assert property (
        eeprom_write_active_in && !ctrl_rdata_out[0] |=> !ctrl_rdata_out[0])
        else $error("command taken during eeprom write");
    done_bound_a: assert property (
        $rose(prog) |-> ##[1:DONE_MAX] !ctrl_rdata_out[0])
        else $error("program did not finish");
    prog_min_a: assert property (
        $rose(prog) |-> prog [*8])
        else $error("program ended too early");

    // Main scenarios
    cover property ($rose(halt_cpu_out));
    cover property (load_valid_out);
    cover property ($fell(rww_read_block_out));
endmodule : sps_seq_monitor

// File: sps_core_model.sv
// Core model issuing control writes, stores and loads
`timescale 1ns/10ps
module sps_core_model (
    input  wire logic             core_clk_in,
    output logic                  ctrl_wr_out,
    output logic [7:0]            ctrl_wdata_out,
    output sps_pkg::sps_cpu_req_t cpu_req_out
);
    // Idle bus at start
    initial begin
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = 8'h00;
        cpu_req_out = '0;
    end

    // Control write strobed for one edge
    task automatic do_ctl(input logic [7:0] v);
        @(negedge core_clk_in);
        ctrl_wr_out = 1'b1;
        ctrl_wdata_out = v;
        @(negedge core_clk_in);
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = ~v;
    endtask : do_ctl

    task automatic do_store(input logic [15:0] a, input logic [15:0] d);
        cpu_req_out = '{store: 1'b1, load: 1'b0, addr: a, data: d};
        @(negedge core_clk_in);
        cpu_req_out = '{store: 1'b0, load: 1'b0, addr: ~a, data: ~d};
    endtask : do_store

    task automatic do_load(input logic [15:0] a);
        cpu_req_out = '{store: 1'b0, load: 1'b1, addr: a, data: 16'h0000};
        @(negedge core_clk_in);
        cpu_req_out = '{store: 1'b0, load: 1'b0, addr: ~a, data: 16'hFFFF};
    endtask : do_load
endmodule : sps_core_model

// File: sps_sequencer_tb_top.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/10ps
module sps_sequencer_tb_top;
    localparam int PROG_CYCLES = 8;
    localparam logic [7:0] SIG0 = 8'h1E; // Arbitrary identity value
    localparam logic [7:0] SIG1 = 8'h95; // Arbitrary identity value
    localparam logic [7:0] SIG2 = 8'h0A; // Arbitrary identity value
    logic clk = 1'b0, reset_n = 1'b0, sys_rst = 1'b0, ee = 1'b0;
    logic [5:0] idx = 6'h00;
    logic [7:0] fuse_lo = 8'h62, fuse_hi = 8'hD9, fuse_ex = 8'hFC, calib = 8'h8E;
    logic wr, lvalid, halt, blk, irq;
    logic [7:0] wdata, rdata, ldata, locks;
    logic [15:0] bdata;
    sps_pkg::sps_cpu_req_t req;
    sps_pkg::sps_flash_t fcmd;
    int err_total = 0;
    int n_compared = 0;
    // Special reads: control, pointer, expected byte
    logic [31:0] rtab [9] = '{32'h090001F5, 32'h09000062, 32'h090003D9,
        32'h090002FC, {8'h21, 16'h0000, SIG0}, {8'h21, 16'h0002, SIG1},
        {8'h21, 16'h0004, SIG2}, 32'h2100018E, 32'h210003FF};

    // Clock
    always #25 clk = ~clk;

    sps_core_model core (.core_clk_in(clk), .ctrl_wr_out(wr),
        .ctrl_wdata_out(wdata), .cpu_req_out(req));

    sps_sequencer #(.PROG_CYCLES(PROG_CYCLES), .SIG_BYTE0(SIG0),
        .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) DUT (
        .core_clk_in(clk), .reset_n_in(reset_n), .sys_reset_in(sys_rst),
        .ctrl_wr_in(wr), .ctrl_wdata_in(wdata), .ctrl_rdata_out(rdata),
        .cpu_req_in(req), .load_valid_out(lvalid), .load_data_out(ldata),
        .eeprom_write_active_in(ee), .fuse_low_byte_in(fuse_lo),
        .fuse_high_byte_in(fuse_hi), .fuse_extended_byte_in(fuse_ex),
        .calib_byte_in(calib), .flash_cmd_out(fcmd),
        .buf_rd_idx_in(idx), .buf_rd_data_out(bdata),
        .lock_bits_out(locks), .halt_cpu_out(halt),
        .rww_read_block_out(blk), .spm_irq_out(irq));

    // Verdict and end of run
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // Compare seen against expected
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // Bounded wait for enable bit to clear
    task automatic wait_idle();
        int n = 0;
        while (rdata[0] !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (rdata[0] !== 1'b0) begin
            err_total++;
            report_and_stop();
        end
    endtask : wait_idle

    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        chk(locks, 8'hFF);
        chk(bdata, 16'hFFFF);
        chk(rdata, 8'h00);
        core.do_ctl(8'h01);
        core.do_store(16'h0006, 16'h1234);
        idx = 6'h03;
        @(negedge clk);
        chk(bdata, 16'h1234);
        $display("reset and fill test done");
        core.do_ctl(8'h83);
        core.do_store(16'h0280, 16'hFFFF);
        chk(fcmd, {2'b10, 7'h05});
        chk(blk, 1'b1);
        chk(halt, 1'b0);
        wait_idle();
        chk(irq, 1'b1);
        chk(blk, 1'b1);
        core.do_ctl(8'h91);
        core.do_store(16'h0000, 16'h0000);
        @(negedge clk);
        chk(blk, 1'b0);
        core.do_ctl(8'h00);
        chk(irq, 1'b0);
        $display("erase test done");
        core.do_ctl(8'h01);
        core.do_store(16'h0006, 16'hABCD);
        core.do_ctl(8'h05);
        core.do_store(16'h3800, 16'h0000);
        chk(fcmd, {2'b01, 7'h70});
        chk(halt, 1'b1);
        wait_idle();
        repeat (2) @(negedge clk);
        chk(bdata, 16'hFFFF);
        chk(halt, 1'b0);
        core.do_ctl(8'h03);
        sys_rst = 1'b1;
        core.do_store(16'h0080, 16'h0000);
        @(negedge clk);
        sys_rst = 1'b0;
        chk(fcmd, {2'b10, 7'h01});
        wait_idle();
        core.do_ctl(8'h11);
        core.do_store(16'h0000, 16'h0000);
        core.do_ctl(8'h01);
        core.do_store(16'h0006, 16'h5555);
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        chk(bdata, 16'hFFFF);
        $display("write and reset test done");
        core.do_ctl(8'h09);
        core.do_store(16'h0001, 16'h00F5);
        chk(blk, 1'b0);
        wait_idle();
        chk(locks, 8'hF5);
        for (int i = 0; i < 9; i++) begin
            core.do_ctl(rtab[i][31:24]);
            core.do_load(rtab[i][23:8]);
            chk(lvalid, 1'b1);
            chk(ldata, rtab[i][7:0]);
            chk(rdata[5:0], 6'h00);
        end
        fuse_hi = 8'h5B;
        calib = 8'h47;
        core.do_ctl(8'h09);
        core.do_load(16'h0003);
        chk(ldata, 8'h5B);
        core.do_ctl(8'h21);
        core.do_load(16'h0001);
        chk(ldata, 8'h47);
        $display("lock and read test done");
        core.do_ctl(8'h09);
        repeat (3) @(negedge clk);
        chk(rdata[3], 1'b1);
        @(negedge clk);
        chk(rdata[5:0], 6'h00);
        core.do_ctl(8'h21);
        repeat (2) @(negedge clk);
        chk(rdata[5], 1'b1);
        @(negedge clk);
        chk(rdata[5:0], 6'h00);
        ee = 1'b1;
        core.do_ctl(8'h05);
        chk(rdata[5:0], 6'h00);
        core.do_ctl(8'h09);
        chk(rdata[5:0], 6'h00);
        // EEPROM idle again before the final report
        ee = 1'b0;
        $display("window and eeprom test done");
        report_and_stop();
    end
endmodule : sps_sequencer_tb_top

bind sps_sequencer sps_seq_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .ctrl_rdata_out(ctrl_rdata_out), .cpu_req_in(cpu_req_in),
    .load_valid_out(load_valid_out),
    .eeprom_write_active_in(eeprom_write_active_in),
    .flash_cmd_out(flash_cmd_out), .lock_bits_out(lock_bits_out),
    .halt_cpu_out(halt_cpu_out), .rww_read_block_out(rww_read_block_out),
    .spm_irq_out(spm_irq_out));
